// ---- fsc_pkg.sv ----
// Purpose: Shared constants for the frame sync correlator and demultiplexer.
// Assumes: 200 MHz pclk, APB3 register access, 32-bit data.
// Notes: Frame length and sync code are fixed at build time.
package fsc_pkg;
  // ==========================================================
  // Line format
  localparam int unsigned SR_W = 30;
  localparam logic [29:0] SYNC_CODE = 30'h1ACF_FC1D;
  localparam int unsigned WORD_W = 10;
  localparam int unsigned FRAME_BITS = 300;
  localparam int unsigned DATA_WORDS = (FRAME_BITS - SR_W) / WORD_W;
  localparam int unsigned POS_W = 9;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] SEARCH_THR_MAX = 5'h04;
  localparam logic [CNT_W-1:0] LOCK_THR_MAX = 5'h0A;

  // ==========================================================
  // Timing
  localparam longint unsigned CLK_HZ = 200000000;
  localparam longint unsigned BIT_RATE_HZ = 9000000;
  localparam int unsigned MIN_BIT_CYC = int'((CLK_HZ + BIT_RATE_HZ - 1) / BIT_RATE_HZ);

  // ==========================================================
  // Register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_INT_STAT = 12'h008;
  localparam logic [11:0] OFS_INT_MASK = 12'h00C;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_STHR_LSB = 4;
  localparam int unsigned CTRL_LTHR_LSB = 8;
  localparam int unsigned STAT_LOCK_BIT = 0;
  localparam int unsigned STAT_MISM_LSB = 8;
  localparam int unsigned STAT_FCNT_LSB = 16;
  localparam int unsigned INT_GAIN_BIT = 0;
  localparam int unsigned INT_LOSS_BIT = 1;
  localparam int unsigned INT_FRAME_BIT = 2;
  localparam int unsigned INT_OVR_BIT = 3;
  localparam int unsigned INT_W = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0421;
  localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;

  typedef enum logic {FSC_SEARCH, FSC_LOCK} fsc_state_t;
endpackage

// ---- fsc_modcnt.sv ----
// Purpose: Wrapping counter with synchronous clear.
// Assumes: Clear wins over increment.
// Notes: Used for the bit position, bit-in-word and word counters.
`timescale 1ns/1ps
`default_nettype none
module fsc_modcnt #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] MAX = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic inc,
  // State
  output logic [W-1:0] cnt,
  output logic wrap
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign wrap = inc && (cnt_r == MAX);
  assign cnt_nxt = clr ? '0 : (wrap ? '0 : (inc ? W'(cnt_r + 1'b1) : cnt_r));
  assign cnt = cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- fsc_correlator.sv ----
// Purpose: Parallel correlator of the shift register against the sync code.
// Assumes: Threshold already clamped by the caller.
// Notes: Purely combinational; the adder tree is left to synthesis.
`timescale 1ns/1ps
`default_nettype none
module fsc_correlator (
  // Data
  input wire logic [fsc_pkg::SR_W-1:0] window,
  input wire logic [fsc_pkg::CNT_W-1:0] thresh,
  // Result
  output logic [fsc_pkg::CNT_W-1:0] mismatches,
  output logic match
);
  import fsc_pkg::*;

  logic [SR_W-1:0] diff;

  assign diff = window ^ SYNC_CODE;

  always_comb begin
    mismatches = '0;
    for (int i = 0; i < SR_W; i++) begin
      mismatches = CNT_W'(mismatches + {{(CNT_W-1){1'b0}}, diff[i]});
    end
  end

  assign match = (mismatches <= thresh);
endmodule
`default_nettype wire

// ---- fsc_sync_demux.sv ----
// Purpose: Frame synchronizer and demultiplexer front end behind an APB slave.
// Assumes: Serial bits arrive as ser_valid pulses synchronous to pclk.
// Notes: Sync code and frame length are package constants.
// What this block does
// - Shift serial bits into a 30-bit register exposing all stages.
// - XOR each stage with the sync code and count the mismatches.
// - Correlation when mismatch count is at or below the active threshold.
// - In search, one correlation within 0-4 errors moves to lock.
// - In lock, one failed check at frame position returns to search.
// - Sync code is a fixed 30-bit value; frame length is fixed.
// - In lock, check only at the single expected bit position.
// - Counters held at preset before correlation, counting only after it.
// - Signal in-sync and hold a frame-lock level output while locked.
// - While locked, route the last ten stages as words to their destination.
// - Frame counter marks each frame boundary so sync is checked once a frame.
// - Check exceeding the lock threshold stops data and restarts search.
// - Any loss of lock ends output data at once.
`timescale 1ns/1ps
`default_nettype none
module fsc_sync_demux (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial input from decoder
  input wire logic ser_data,
  input wire logic ser_valid,
  // Demultiplexer output
  output logic [fsc_pkg::WORD_W-1:0] word_data,
  output logic [fsc_pkg::POS_W-1:0] word_dest,
  output logic word_valid,
  // Timing and control
  output logic frame_lock,
  output logic in_sync,
  output logic frame_tick,
  // Interrupt
  output logic irq
);
  import fsc_pkg::*;

  // ==========================================================
  // Registers and state
  fsc_state_t state_r;
  fsc_state_t state_nxt;
  logic [SR_W-1:0] sr_r;
  logic shifted_r;
  logic [31:0] ctrl_r;
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_stat_nxt;
  logic [INT_W-1:0] int_mask_r;
  logic [15:0] frame_cnt_r;
  logic [CNT_W-1:0] last_mism_r;
  logic [WORD_W-1:0] word_data_r;
  logic [POS_W-1:0] word_dest_r;
  logic word_valid_r;
  logic frame_tick_r;
  logic [4:0] gap_r;

  // ==========================================================
  // APB decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire [11:0] ofs = paddr[11:0];
  wire hit_ctrl = (ofs == OFS_CTRL);
  wire hit_stat = (ofs == OFS_STATUS);
  wire hit_ist = (ofs == OFS_INT_STAT);
  wire hit_imsk = (ofs == OFS_INT_MASK);
  wire mapped = (paddr[31:12] == 20'h0_0000) && (hit_ctrl || hit_stat || hit_ist || hit_imsk);
  wire ist_rd_clr = rd_en && mapped && hit_ist;

  wire [CNT_W-1:0] sthr_raw = {2'b00, ctrl_r[CTRL_STHR_LSB +: 3]};
  wire [CNT_W-1:0] lthr_raw = {1'b0, ctrl_r[CTRL_LTHR_LSB +: 4]};
  wire [CNT_W-1:0] sthr = (sthr_raw > SEARCH_THR_MAX) ? SEARCH_THR_MAX : sthr_raw;
  wire [CNT_W-1:0] lthr = (lthr_raw > LOCK_THR_MAX) ? LOCK_THR_MAX : lthr_raw;
  wire enable = ctrl_r[CTRL_EN_BIT];

  wire [31:0] status_word = {frame_cnt_r, 3'h0, last_mism_r, 7'h00, (state_r == FSC_LOCK)};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_stat ? status_word :
                       hit_ist ? {28'h000_0000, int_stat_r} :
                       {28'h000_0000, int_mask_r};

  // No wait states; an unmapped address errors and reads zero
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = (rd_en && mapped) ? rd_mux : 32'h0000_0000;

  // ==========================================================
  // Correlator and counters
  wire locked = (state_r == FSC_LOCK);
  wire [CNT_W-1:0] thresh = locked ? lthr : sthr;
  wire [CNT_W-1:0] mism;
  wire match;
  wire [POS_W-1:0] pos;
  wire [3:0] bit_in_word;
  wire [POS_W-1:0] word_idx;
  wire run = locked && enable;

  fsc_correlator u_corr (
    .window(sr_r),
    .thresh(thresh),
    .mismatches(mism),
    .match(match)
  );

  fsc_modcnt #(.W(POS_W), .MAX(POS_W'(FRAME_BITS - 1))) u_pos (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!run),
    .inc(ser_valid),
    .cnt(pos),
    .wrap()
  );

  fsc_modcnt #(.W(4), .MAX(4'(WORD_W - 1))) u_bit (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!run),
    .inc(ser_valid),
    .cnt(bit_in_word),
    .wrap()
  );

  wire check = shifted_r && locked && (pos == '0);
  wire check_fail = check && !match;
  wire gain = shifted_r && !locked && enable && match;
  wire emit = shifted_r && locked && (bit_in_word == 4'h0) && (pos != '0)
              && (pos <= POS_W'(FRAME_BITS - SR_W));

  fsc_modcnt #(.W(POS_W), .MAX(POS_W'(DATA_WORDS - 1))) u_word (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!run),
    .inc(emit && enable),
    .cnt(word_idx),
    .wrap()
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSC_SEARCH: begin
        if (gain) begin
          state_nxt = FSC_LOCK;
        end
      end
      FSC_LOCK: begin
        if (check_fail || !enable) begin
          state_nxt = FSC_SEARCH;
        end
      end
      default: begin
        state_nxt = FSC_SEARCH;
      end
    endcase
  end

  wire overrun = ser_valid && (gap_r < 5'(MIN_BIT_CYC - 1));
  wire [INT_W-1:0] events = {overrun, check && match, check_fail || (locked && !enable), gain};
  wire [INT_W-1:0] ist_kept = ist_rd_clr ? {INT_W{1'b0}} : int_stat_r;

  // Set wins over the read clear
  assign int_stat_nxt = ist_kept | events;

  // ==========================================================
  // Sequential logic
  // reset state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FSC_SEARCH;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_r <= '0;
      shifted_r <= 1'b0;
    end else begin
      shifted_r <= ser_valid;
      if (ser_valid) begin
        sr_r <= {sr_r[SR_W-2:0], ser_data};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 5'h1F;
    end else if (ser_valid) begin
      gap_r <= 5'h00;
    end else if (gap_r != 5'h1F) begin
      gap_r <= gap_r + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      int_mask_r <= INT_MASK_RST;
    end else if (wr_en && mapped) begin
      if (hit_ctrl) begin
        ctrl_r <= {20'h0_0000, pwdata[11:8], 1'b0, pwdata[6:4], 3'h0, pwdata[0]};
      end
      if (hit_imsk) begin
        int_mask_r <= pwdata[INT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_r <= 16'h0000;
      frame_tick_r <= 1'b0;
      last_mism_r <= '0;
    end else begin
      frame_tick_r <= check;
      if (check && match) begin
        frame_cnt_r <= frame_cnt_r + 16'h0001;
      end
      if (shifted_r) begin
        last_mism_r <= mism;
      end
    end
  end

  // output gated by next lock state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_valid_r <= 1'b0;
      word_data_r <= '0;
      word_dest_r <= '0;
    end else begin
      word_valid_r <= emit && (state_nxt == FSC_LOCK);
      if (emit) begin
        word_data_r <= sr_r[WORD_W-1:0];
        word_dest_r <= word_idx;
      end
    end
  end

  assign frame_lock = locked;
  assign in_sync = locked;
  assign word_valid = word_valid_r;
  assign word_data = word_data_r;
  assign word_dest = word_dest_r;
  assign frame_tick = frame_tick_r;
  assign irq = |(int_stat_r & int_mask_r);

  // ==========================================================
  // Checks
  chk_search_gain: assert property (@(posedge pclk) disable iff (!presetn)
    (!locked && shifted_r && enable && mism <= sthr) |=> frame_lock)
    else $error("lock not taken on search correlation");
  chk_lock_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (locked && shifted_r && pos == '0 && mism > lthr) |=> !frame_lock && !word_valid)
    else $error("lock kept after failed frame check");
  chk_aperture_only: assert property (@(posedge pclk) disable iff (!presetn)
    (locked && enable && pos != '0) |=> frame_lock)
    else $error("lock lost away from frame position");
  chk_preset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !frame_lock |=> (pos == '0 && bit_in_word == 4'h0 && word_idx == '0))
    else $error("counters left preset while searching");
  chk_word_source: assert property (@(posedge pclk) disable iff (!presetn)
    (emit && enable && !check_fail) |=> word_valid && word_data == $past(sr_r[9:0]))
    else $error("word not taken from last ten stages");
  chk_word_locked: assert property (@(posedge pclk) disable iff (!presetn)
    word_valid |-> frame_lock && $past(frame_lock))
    else $error("word output without lock");
  chk_frame_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (shifted_r && locked && pos == '0) |=> frame_tick ##1 !frame_tick)
    else $error("frame boundary not marked once");
  chk_gain_irq: assert property (@(posedge pclk) disable iff (!presetn)
    gain |=> int_stat_r[INT_GAIN_BIT] && frame_lock)
    else $error("lock gain not flagged");
  chk_corr_count: assert property (@(posedge pclk) disable iff (!presetn)
    match == ($countones(sr_r ^ SYNC_CODE) <= thresh))
    else $error("correlator decision wrong");
  chk_corr_decision: assert property (@(posedge pclk) disable iff (!presetn)
    (!locked && shifted_r && enable && mism > sthr) |=> !frame_lock)
    else $error("lock taken above search threshold");
  chk_enable_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (locked && !enable) |=> !frame_lock && !word_valid)
    else $error("output kept after lock loss");
  chk_reset_state: assert property (@(posedge pclk)
    $rose(presetn) |-> !frame_lock && !word_valid && pos == '0)
    else $error("reset state wrong");
endmodule
`default_nettype wire

// ---- fsc_ser_src.sv ----
// Purpose: Serial bit source standing in for the upstream decoder.
// Assumes: One pclk-wide strobe per bit, driven right after a rising edge.
// Notes: Between strobes the data line shows the inverse of the last bit.
`timescale 1ns/1ps
`default_nettype none
module fsc_ser_src (
  // Clock
  input wire logic pclk,
  // Serial link
  output logic ser_data,
  output logic ser_valid
);
  import fsc_pkg::*;

  initial begin
    ser_data = 1'b0;
    ser_valid = 1'b0;
  end

  // ==========================================================
  // Bit strobe
  // bit spacing
  task automatic send(input logic b, input int gap);
    ser_data <= b;
    ser_valid <= 1'b1;
    @(posedge pclk);
    ser_valid <= 1'b0;
    // A stale level would hide a late sample, so the line flips
    ser_data <= ~b;
    repeat (gap - 1) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- test_frame_sync_correlator_demux.sv ----
// Purpose: Self-checking bench for the frame synchronizer and demultiplexer.
// Assumes: Zero-wait APB slave; bits spaced at the 9 MHz minimum.
// Notes: Words are queued by the driver and matched by the output monitor.
`timescale 1ns/1ps
`default_nettype none
module test_frame_sync_correlator_demux;
  import fsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, ser_data, ser_valid;
  logic word_valid, frame_lock, in_sync, frame_tick, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [WORD_W-1:0] word_data, w;
  logic [POS_W-1:0] word_dest;
  logic [POS_W+WORD_W-1:0] exp_q[$];
  int err_count = 0;
  int n_checks = 0;
  int n_tick = 0;
  int base, e;

  fsc_sync_demux uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ser_data(ser_data), .ser_valid(ser_valid), .word_data(word_data),
    .word_dest(word_dest), .word_valid(word_valid), .frame_lock(frame_lock),
    .in_sync(in_sync), .frame_tick(frame_tick), .irq(irq));
  fsc_ser_src src (.pclk(pclk), .ser_data(ser_data), .ser_valid(ser_valid));

  always #2.5 pclk = ~pclk;

  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp_v);
    n_checks++;
    if (seen !== exp_v) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp_v, seen);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Drivers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask

  // Oldest bit first
  task automatic send_bits(input logic [29:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) src.send(v[i], MIN_BIT_CYC);
  endtask

  function automatic logic [31:0] ctrl_val(input logic en, input int s, input int l);
    return (32'(l) << CTRL_LTHR_LSB) | (32'(s) << CTRL_STHR_LSB) | {31'h0, en};
  endfunction

  // ==========================================================
  // Output monitor
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      chk("in_sync", in_sync, frame_lock);
      if (frame_tick === 1'b1) n_tick++;
      if (word_valid === 1'b1) begin
        chk("lock_at_word", frame_lock, 1);
        if (exp_q.size() == 0) chk("extra_word", 1, 0);
        else chk("word", {word_dest, word_data}, exp_q.pop_front());
      end
    end
  end

  initial begin
    #(5 * 90000);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    void'($urandom(32'h91DA));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("lock_rst", frame_lock, 0);
    chk("irq_rst", irq, 0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_rst", rd, CTRL_RST);
    apb(1'b0, OFS_INT_MASK, 32'h0);
    chk("mask_rst", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", er, 1);
    chk("unmapped_rd", rd, 32'h0);
    // Two bits far too close together
    src.send(1'b1, 2);
    src.send(1'b0, MIN_BIT_CYC);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk("overrun", rd[INT_OVR_BIT], 1);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk("stat_cleared", rd, 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h3);
    // Search threshold boundary, one over then exactly at it
    for (int t = 0; t <= 4; t++) begin
      apb(1'b1, OFS_CTRL, ctrl_val(1'b1, t, 4));
      send_bits(SYNC_CODE ^ ((30'h1 << (t + 1)) - 30'h1), 30);
      chk("lock_miss", frame_lock, 0);
      send_bits(SYNC_CODE ^ ((30'h1 << t) - 30'h1), 30);
      chk("lock_hit", frame_lock, 1);
      chk("irq_gain", irq, 1);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk("gain_flag", rd[INT_GAIN_BIT], 1);
      settle();
      chk("irq_clear", irq, 0);
      apb(1'b1, OFS_CTRL, ctrl_val(1'b0, t, 4));
      settle();
      chk("lock_off", frame_lock, 0);
      chk("irq_loss", irq, 1);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk("loss_flag", rd[INT_LOSS_BIT], 1);
    end
    // Locked frames: lock threshold 3, then 3, 0 and 4 sync errors
    apb(1'b1, OFS_CTRL, ctrl_val(1'b1, 4, 3));
    send_bits(SYNC_CODE, 30);
    base = n_tick;
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < DATA_WORDS; k++) begin
        w = WORD_W'($urandom);
        exp_q.push_back({POS_W'(k), w});
        send_bits({20'h0, w}, 10);
      end
      e = (f == 0) ? 3 : ((f == 1) ? 0 : 4);
      send_bits(SYNC_CODE ^ ((30'h1 << e) - 30'h1), 30);
      chk("ticks", n_tick - base, f + 1);
      chk("lock_keep", frame_lock, f < 2);
      if (f < 2) begin
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rd, {16'(f + 1), 3'h0, 5'(e), 7'h0, 1'b1});
        apb(1'b0, OFS_INT_STAT, 32'h0);
        chk("frame_flag", rd[INT_FRAME_BIT], 1);
      end
    end
    chk("words_left", exp_q.size(), 0);
    send_bits(30'(SYNC_CODE ^ 30'h2AAA_AAAA), 30);
    chk("no_relock", frame_lock, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
